// file: core/tdt_tick_timer.sv
// Tick divider timer: 8-bit 256 Hz up-counter with hold, run/clear and tick interrupts.
// Assumes synchronous inputs, one 100 MHz clock, synchronous active-high reset.
//
// Notes on behaviour
// - Eight-bit up-counter stepped by divided tick.
// - Low and high nibbles read at two addresses.
// - Low read freezes high nibble until high read.
// - Hold ends after at most the hold interval.
// - Reading high nibble never starts a hold.
// - Falling 16/8/2/1 Hz bits set flags, enabled or not; a fall caused by a clear sets none.
// - Enable bits pass or mask each tick interrupt.
// - Flags read one; write one clears them.
// - Uncleared flag keeps interrupt request asserted.
// - Clear strobe zeroes counter, reads zero.
// - Clear resumes counting if running, else holds.
// - Run bit starts and stops, count retained.
// - Count nibbles read-only, writes ignored.
// - Reset zeroes counter, run, enables, flags.
`timescale 1ns/100ps

module tdt_tick_timer #(
    parameter int unsigned TICK_CYCLES = tdt_pkg::TICK_CYCLES,
    parameter int unsigned HOLD_CYCLES = tdt_pkg::HOLD_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [31:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    output logic [1:0] AXI_BRESP_O,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [31:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    output logic IRQ_O
);

    localparam int unsigned DIV_W = $clog2(TICK_CYCLES);
    localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

    // Write channel state
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic wr_do;
    logic next_aw_held;
    logic next_w_held;
    logic wr_low_lane;

    // Read channel state
    logic ar_take;
    logic r_done;

    // Block state
    logic count_run_enable;
    logic [3:0] irq_enables;
    logic [3:0] irq_flags;
    logic [3:0] cnt_low;
    logic [3:0] cnt_high;
    logic [DIV_W-1:0] div_cnt;
    logic tick_en;
    logic hold;
    logic [HOLD_W-1:0] hold_cnt;
    logic hold_end;
    logic carry_pend;
    logic low_carry;
    logic [3:0] prev_bits;
    logic [3:0] cur_bits;
    logic [3:0] fall;

    // Decoded strobes
    logic wr_ctrl;
    logic wr_en;
    logic wr_flag;
    logic clr_req;
    logic rd_low_fire;
    logic rd_high_fire;
    logic [3:0] w1c_mask;

    assign aw_take = AXI_AWVALID_I && AXI_AWREADY_O;
    assign w_take = AXI_WVALID_I && AXI_WREADY_O;
    assign wr_do = aw_held && w_held && !AXI_BVALID_O;
    assign next_aw_held = aw_take || (aw_held && !wr_do);
    assign next_w_held = w_take || (w_held && !wr_do);
    assign wr_low_lane = w_strb[0];
    assign ar_take = AXI_ARVALID_I && AXI_ARREADY_O;
    assign r_done = AXI_RVALID_O && AXI_RREADY_I;

    assign wr_ctrl = wr_do && wr_low_lane && (aw_addr == tdt_pkg::ADDR_CTRL);
    assign wr_en = wr_do && wr_low_lane && (aw_addr == tdt_pkg::ADDR_IRQ_EN);
    assign wr_flag = wr_do && wr_low_lane && (aw_addr == tdt_pkg::ADDR_IRQ_FLAG);
    assign clr_req = wr_ctrl && w_data[tdt_pkg::CTRL_CLR_BIT];
    assign w1c_mask = wr_flag ? w_data[3:0] : tdt_pkg::NIB_RESET;
    assign rd_low_fire = ar_take && (AXI_ARADDR_I == tdt_pkg::ADDR_CNT_LOW);
    assign rd_high_fire = ar_take && (AXI_ARADDR_I == tdt_pkg::ADDR_CNT_HIGH);

    assign tick_en = count_run_enable && (div_cnt == DIV_LAST);
    assign low_carry = tick_en && (cnt_low == tdt_pkg::NIB_ALL_ONES);
    assign hold_end = hold && (rd_high_fire || hold_cnt == HOLD_LAST);

    assign cur_bits[tdt_pkg::FL_16HZ] = cnt_low[tdt_pkg::BIT_16HZ_LOW];
    assign cur_bits[tdt_pkg::FL_8HZ] = cnt_high[tdt_pkg::BIT_8HZ_HIGH];
    assign cur_bits[tdt_pkg::FL_2HZ] = cnt_high[tdt_pkg::BIT_2HZ_HIGH];
    assign cur_bits[tdt_pkg::FL_1HZ] = cnt_high[tdt_pkg::BIT_1HZ_HIGH];
    assign fall = prev_bits & ~cur_bits;

    // Write address capture
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            AXI_AWREADY_O <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            AXI_AWREADY_O <= !next_aw_held;
            if (aw_take) begin
                aw_addr <= AXI_AWADDR_I;
            end
        end
    end

    // Write data capture
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            AXI_WREADY_O <= 1'b0;
        end else begin
            w_held <= next_w_held;
            AXI_WREADY_O <= !next_w_held;
            if (w_take) begin
                w_data <= AXI_WDATA_I;
                w_strb <= AXI_WSTRB_I;
            end
        end
    end

    // Write response; count nibbles accept writes silently
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            AXI_BVALID_O <= 1'b0;
            AXI_BRESP_O <= tdt_pkg::RESP_OKAY;
        end else if (wr_do) begin
            AXI_BVALID_O <= 1'b1;
            case (aw_addr)
                tdt_pkg::ADDR_CTRL,
                tdt_pkg::ADDR_CNT_LOW,
                tdt_pkg::ADDR_CNT_HIGH,
                tdt_pkg::ADDR_IRQ_EN,
                tdt_pkg::ADDR_IRQ_FLAG: AXI_BRESP_O <= tdt_pkg::RESP_OKAY;
                default: AXI_BRESP_O <= tdt_pkg::RESP_SLVERR;
            endcase
        end else if (AXI_BVALID_O && AXI_BREADY_I) begin
            AXI_BVALID_O <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O <= 1'b0;
            AXI_RDATA_O <= '0;
            AXI_RRESP_O <= tdt_pkg::RESP_OKAY;
        end else if (ar_take) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O <= 1'b1;
            AXI_RRESP_O <= tdt_pkg::RESP_OKAY;
            case (AXI_ARADDR_I)
                tdt_pkg::ADDR_CTRL: AXI_RDATA_O <= {31'h0, count_run_enable};
                tdt_pkg::ADDR_CNT_LOW: AXI_RDATA_O <= {28'h0000000, cnt_low};
                tdt_pkg::ADDR_CNT_HIGH: AXI_RDATA_O <= {28'h0000000, cnt_high};
                tdt_pkg::ADDR_IRQ_EN: AXI_RDATA_O <= {28'h0000000, irq_enables};
                tdt_pkg::ADDR_IRQ_FLAG: AXI_RDATA_O <= {28'h0000000, irq_flags};
                default: begin
                    AXI_RDATA_O <= '0;
                    AXI_RRESP_O <= tdt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (r_done || !AXI_RVALID_O) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O <= 1'b0;
        end
    end

    // Run bit and interrupt enables
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            count_run_enable <= 1'b0;
            irq_enables <= tdt_pkg::NIB_RESET;
        end else begin
            if (wr_ctrl) begin
                count_run_enable <= w_data[tdt_pkg::CTRL_RUN_BIT];
            end
            if (wr_en) begin
                irq_enables <= w_data[3:0];
            end
        end
    end

    // Tick divider; restarts on clear so counting resumes at once
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || clr_req) begin
            div_cnt <= '0;
        end else if (count_run_enable) begin
            div_cnt <= tick_en ? '0 : div_cnt + DIV_W'(1);
        end
    end

    // Low nibble
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || clr_req) begin
            cnt_low <= tdt_pkg::NIB_RESET;
        end else if (tick_en) begin
            cnt_low <= cnt_low + tdt_pkg::NIB_ONE;
        end
    end

    // High nibble, frozen during a hold
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || clr_req) begin
            cnt_high <= tdt_pkg::NIB_RESET;
            carry_pend <= 1'b0;
        end else if (hold) begin
            if (low_carry) begin
                carry_pend <= 1'b1;
            end
        end else if (low_carry || carry_pend) begin
            cnt_high <= cnt_high + tdt_pkg::NIB_ONE;
            carry_pend <= 1'b0;
        end
    end

    // Hold window
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            hold <= 1'b0;
            hold_cnt <= '0;
        end else if (rd_low_fire) begin
            hold <= 1'b1;
            hold_cnt <= '0;
        end else if (hold_end) begin
            hold <= 1'b0;
            hold_cnt <= '0;
        end else if (hold) begin
            hold_cnt <= hold_cnt + HOLD_W'(1);
        end
    end

    // Edge history; cleared with the count so a clear is no edge
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || clr_req) begin
            prev_bits <= tdt_pkg::NIB_RESET;
        end else begin
            prev_bits <= cur_bits;
        end
    end

    // Sticky flags, set wins over clear
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            irq_flags <= tdt_pkg::NIB_RESET;
        end else begin
            irq_flags <= (irq_flags & ~w1c_mask) | fall;
        end
    end

    // Interrupt level
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_flags & irq_enables);
        end
    end

    // Checks
    default clocking chk_cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);

    sequence low_read_s;
        rd_low_fire && !clr_req;
    endsequence

    sequence held_quiet_s;
        hold && !hold_end && !clr_req;
    endsequence

    cnt_step_a: assert property (
        (tick_en && !clr_req) |=> cnt_low == $past(cnt_low) + tdt_pkg::NIB_ONE)
        else $error("low nibble did not step on tick");

    hold_start_a: assert property (
        low_read_s |=> hold && hold_cnt == '0)
        else $error("low read did not start hold");

    high_frozen_a: assert property (
        held_quiet_s |=> $stable(cnt_high))
        else $error("high nibble moved during hold");

    hold_limit_a: assert property (
        hold |-> hold_cnt <= HOLD_LAST)
        else $error("hold outlived its interval");

    carry_kept_a: assert property (
        (hold && low_carry && !clr_req) |=> carry_pend)
        else $error("carry during hold was lost");

    carry_applied_a: assert property (
        (!hold && carry_pend && !clr_req) |=> cnt_high == $past(cnt_high) + tdt_pkg::NIB_ONE && !carry_pend)
        else $error("pending carry not applied");

    high_nohold_a: assert property (
        (rd_high_fire && !hold) |=> !hold)
        else $error("high read started a hold");

    flag_set_a: assert property (
        fall[tdt_pkg::FL_16HZ] |=> irq_flags[tdt_pkg::FL_16HZ])
        else $error("16 Hz fall did not set flag");

    irq_level_a: assert property (
        |(irq_flags & irq_enables) |=> IRQ_O)
        else $error("interrupt not raised for enabled flag");

    irq_masked_a: assert property (
        (irq_flags & irq_enables) == tdt_pkg::NIB_RESET |=> !IRQ_O)
        else $error("interrupt raised while masked");

    flag_clear_a: assert property (
        (w1c_mask[tdt_pkg::FL_1HZ] && !fall[tdt_pkg::FL_1HZ]) |=> !irq_flags[tdt_pkg::FL_1HZ])
        else $error("write one did not clear flag");

    clear_zero_a: assert property (
        clr_req |=> cnt_low == tdt_pkg::NIB_RESET && cnt_high == tdt_pkg::NIB_RESET)
        else $error("clear strobe did not zero count");

    stop_keep_a: assert property (
        (!count_run_enable && !clr_req && !carry_pend) |=> $stable(cnt_low) && $stable(cnt_high))
        else $error("count moved while stopped");

    reset_state_a: assert property (
        $past(RESET_I) |-> cnt_low == tdt_pkg::NIB_RESET && irq_flags == tdt_pkg::NIB_RESET && !count_run_enable)
        else $error("state not cleared by reset");

    hold_release_a: assert property (
        (hold && rd_high_fire) |=> !hold)
        else $error("high read did not end hold");

    carry_step_a: assert property (
        (low_carry && !hold && !carry_pend && !clr_req) |=> cnt_high == $past(cnt_high) + tdt_pkg::NIB_ONE)
        else $error("high nibble missed low carry");

    flag_keep_a: assert property (
        (irq_flags[tdt_pkg::FL_1HZ] && !w1c_mask[tdt_pkg::FL_1HZ]) |=> irq_flags[tdt_pkg::FL_1HZ])
        else $error("uncleared flag was lost");

endmodule // tdt_tick_timer

// file: include/tdt_pkg.sv
// Constants, register map and timing for the tick divider timer.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package tdt_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    // Counter input rate: bit 0 toggles at 128 Hz
    localparam int unsigned TICK_HZ = 256;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
    // Longest high-nibble hold, in microseconds, rounded down to cycles
    localparam int unsigned HOLD_MAX_US = 1500;
    localparam int unsigned HOLD_CYCLES = HOLD_MAX_US * CLK_MHZ;

    // Widths
    localparam int unsigned NIB_W = 4;
    localparam int unsigned DATA_W = 32;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_CTRL = 16'hff78;
    localparam logic [15:0] IDX_CNT_LOW = 16'hff79;
    localparam logic [15:0] IDX_CNT_HIGH = 16'hff7a;
    localparam logic [15:0] IDX_IRQ_EN = 16'hffe6;
    localparam logic [15:0] IDX_IRQ_FLAG = 16'hfff6;
    localparam logic [31:0] ADDR_CTRL = {14'h0, IDX_CTRL, 2'h0};
    localparam logic [31:0] ADDR_CNT_LOW = {14'h0, IDX_CNT_LOW, 2'h0};
    localparam logic [31:0] ADDR_CNT_HIGH = {14'h0, IDX_CNT_HIGH, 2'h0};
    localparam logic [31:0] ADDR_IRQ_EN = {14'h0, IDX_IRQ_EN, 2'h0};
    localparam logic [31:0] ADDR_IRQ_FLAG = {14'h0, IDX_IRQ_FLAG, 2'h0};

    // Control fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_CLR_BIT = 1;

    // Flag and enable bit order: 16, 8, 2, 1 Hz
    localparam int unsigned FL_16HZ = 0;
    localparam int unsigned FL_8HZ = 1;
    localparam int unsigned FL_2HZ = 2;
    localparam int unsigned FL_1HZ = 3;
    // Counter bit positions within their nibble
    localparam int unsigned BIT_16HZ_LOW = 3;
    localparam int unsigned BIT_8HZ_HIGH = 0;
    localparam int unsigned BIT_2HZ_HIGH = 2;
    localparam int unsigned BIT_1HZ_HIGH = 3;

    // Nibble constants: reset value, all ones, one
    localparam logic [3:0] NIB_RESET = 4'h0;
    localparam logic [3:0] NIB_ALL_ONES = 4'hf;
    localparam logic [3:0] NIB_ONE = 4'h1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: tb/tdt_tick_timer_test.sv
// Self-checking bench for the tick divider timer, driven over AXI4-Lite.
// Assumes the timer core with shortened tick and hold counts, one 100 MHz clock.
`timescale 1ns/100ps

module tdt_tick_timer_test;
    localparam int unsigned TICKS = 8;
    localparam int unsigned HOLD = 20;
    localparam logic [31:0] BAD_ADDR = 32'h0000_0010;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0] wstrb, fl, e;
    logic [1:0] bresp, rresp;
    logic [7:0] c1, c2;
    int bad_count, check_count;
    logic [31:0] regs [5];

    tdt_tick_timer #(.TICK_CYCLES(TICKS), .HOLD_CYCLES(HOLD)) dut (
        .CLOCK_I(clk), .RESET_I(rst),
        .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
        .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
        .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
        .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
        .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
        .IRQ_O(irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic irq_exp(input logic [3:0] en, input logic [3:0] flags);
        return |(en & flags);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok) && n < 100) begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) bad_count++;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        v = rdata;
        if (n >= 100) bad_count++;
        check({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic rdcnt(output logic [7:0] c);
        logic [31:0] v;
        rd(tdt_pkg::ADDR_CNT_LOW, tdt_pkg::RESP_OKAY, v);
        c[3:0] = v[3:0];
        rd(tdt_pkg::ADDR_CNT_HIGH, tdt_pkg::RESP_OKAY, v);
        c[7:4] = v[3:0];
    endtask

    // Catch a low nibble of 15, let its carry land inside the hold, then end the hold by a high read or by expiry
    task automatic hold_case(input bit early);
        logic [31:0] h, l2, v;
        int k;
        k = 0;
        l2 = 32'h0;
        while (l2[3:0] !== 4'hf && k < 200) begin
            rd(tdt_pkg::ADDR_CNT_HIGH, tdt_pkg::RESP_OKAY, h);
            repeat (3) @(posedge clk);
            rd(tdt_pkg::ADDR_CNT_LOW, tdt_pkg::RESP_OKAY, l2);
            k++;
        end
        check({28'h0, l2[3:0]}, 32'hf);
        if (early) begin
            repeat (10) @(posedge clk);
            rd(tdt_pkg::ADDR_CNT_HIGH, tdt_pkg::RESP_OKAY, v);
            check(v, {28'h0, h[3:0]});
            repeat (2) @(posedge clk);
            rd(tdt_pkg::ADDR_CNT_HIGH, tdt_pkg::RESP_OKAY, v);
            check(v, {28'h0, h[3:0] + 4'h1});
        end else begin
            repeat (HOLD + TICKS + 4) @(posedge clk);
            rd(tdt_pkg::ADDR_CNT_HIGH, tdt_pkg::RESP_OKAY, v);
            check(v, {28'h0, h[3:0] + 4'h1});
        end
    endtask

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, arvalid} = 3'h0;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        bad_count = 0;
        check_count = 0;
        regs = '{tdt_pkg::ADDR_CTRL, tdt_pkg::ADDR_CNT_LOW, tdt_pkg::ADDR_CNT_HIGH,
                 tdt_pkg::ADDR_IRQ_EN, tdt_pkg::ADDR_IRQ_FLAG};
        void'($urandom(33));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Reset values and unmapped space
        foreach (regs[i]) begin
            rd(regs[i], tdt_pkg::RESP_OKAY, d);
            check(d, 32'h0);
        end
        check({31'h0, irq}, 32'h0);
        wr(BAD_ADDR, 32'hf, tdt_pkg::RESP_SLVERR);
        rd(BAD_ADDR, tdt_pkg::RESP_SLVERR, d);
        check(d, 32'h0);
        // Run past a full wrap with all enables off
        wr(tdt_pkg::ADDR_CTRL, 32'h3, tdt_pkg::RESP_OKAY);
        repeat (260 * TICKS) @(posedge clk);
        wr(tdt_pkg::ADDR_CTRL, 32'h0, tdt_pkg::RESP_OKAY);
        rd(tdt_pkg::ADDR_IRQ_FLAG, tdt_pkg::RESP_OKAY, d);
        check(d, 32'hf);
        fl = 4'hf;
        check({31'h0, irq}, 32'h0);
        // Stopped count is kept and ignores writes
        rdcnt(c1);
        check({31'h0, c1 != 8'h0}, 32'h1);
        repeat (50) @(posedge clk);
        rdcnt(c2);
        check({24'h0, c2}, {24'h0, c1});
        wr(tdt_pkg::ADDR_CNT_LOW, $urandom, tdt_pkg::RESP_OKAY);
        wr(tdt_pkg::ADDR_CNT_HIGH, $urandom, tdt_pkg::RESP_OKAY);
        rdcnt(c2);
        check({24'h0, c2}, {24'h0, c1});
        // Each enable alone, then random masks
        for (int i = 0; i < 6; i++) begin
            e = (i < 4) ? 4'h1 << i : 4'($urandom);
            wr(tdt_pkg::ADDR_IRQ_EN, {28'h0, e}, tdt_pkg::RESP_OKAY);
            rd(tdt_pkg::ADDR_IRQ_EN, tdt_pkg::RESP_OKAY, d);
            check(d, {28'h0, e});
            repeat (3) @(posedge clk);
            check({31'h0, irq}, {31'h0, irq_exp(e, fl)});
        end
        // Write-one-to-clear flags
        wr(tdt_pkg::ADDR_IRQ_FLAG, 32'h0, tdt_pkg::RESP_OKAY);
        rd(tdt_pkg::ADDR_IRQ_FLAG, tdt_pkg::RESP_OKAY, d);
        check(d, {28'h0, fl});
        for (int i = 0; i < 3; i++) begin
            d = (i < 2) ? {28'h0, 4'($urandom)} : 32'hf;
            wr(tdt_pkg::ADDR_IRQ_FLAG, d, tdt_pkg::RESP_OKAY);
            fl = fl & ~d[3:0];
            rd(tdt_pkg::ADDR_IRQ_FLAG, tdt_pkg::RESP_OKAY, d);
            check(d, {28'h0, fl});
            repeat (3) @(posedge clk);
            check({31'h0, irq}, {31'h0, irq_exp(e, fl)});
        end
        // Clear while stopped, then while running
        wr(tdt_pkg::ADDR_CTRL, 32'h2, tdt_pkg::RESP_OKAY);
        repeat (30) @(posedge clk);
        rdcnt(c2);
        check({24'h0, c2}, 32'h0);
        rd(tdt_pkg::ADDR_CTRL, tdt_pkg::RESP_OKAY, d);
        check(d, 32'h0);
        wr(tdt_pkg::ADDR_CTRL, 32'h1, tdt_pkg::RESP_OKAY);
        repeat (40) @(posedge clk);
        rdcnt(c2);
        check({31'h0, c2 > 8'h3}, 32'h1);
        wr(tdt_pkg::ADDR_CTRL, 32'h3, tdt_pkg::RESP_OKAY);
        rdcnt(c2);
        check({31'h0, c2 <= 8'h1}, 32'h1);
        rd(tdt_pkg::ADDR_CTRL, tdt_pkg::RESP_OKAY, d);
        check(d, 32'h1);
        // Write with lane 0 off leaves control alone
        wstrb <= 4'he;
        wr(tdt_pkg::ADDR_CTRL, 32'h2, tdt_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd(tdt_pkg::ADDR_CTRL, tdt_pkg::RESP_OKAY, d);
        check(d, 32'h1);
        // High-nibble hold, ended by a read and by expiry
        hold_case(1'b1);
        hold_case(1'b0);
        // Reset in mid-run clears everything again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (regs[i]) begin
            rd(regs[i], tdt_pkg::RESP_OKAY, d);
            check(d, 32'h0);
        end
        check({31'h0, irq}, 32'h0);
        report_and_stop();
    end

    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule // tdt_tick_timer_test
